// *** shared/dvs_pkg.sv ***
// Overview of operation
// (R01) DAC fed from first or second target
// (R02) Go bit starts ramp, self-clears when done
// (R03) Alert clear register access releases alert high
// (R04) Data written to alert clear discarded
// (R05) Targets hold 5-bit code in bits 4:0
// (R06) Standby pin high forces second target
// (R07) Host writes go bits to apply targets
// (R08) Mask bit low forces power-good low ramping
// (R09) First buck bits 7:6 set edge rate
// (R10) Second target bit 5 picks buck frequency
// (R11) Bit 7 selects keep-alive shutdown behaviour
// (R12) Second target bit 6 picks clock phase
// (R13) Code steps 12.5mV from 362.5mV, reset 11001
// (R14) Each DAC has own two-bit ramp field
// (R15) Ramp codes 0.88 to 7 mV/us, reset ones
// (R16) Base variant bit 7 picks aux enable source
// (R17) Base variant bits 6:5 pick aux voltage
// (R18) Alternate variant bit 7 unused, other voltages
// (R19) Output-good status one bit per rail
// (R20) Fault status flags in bits 7,5,4,3
// (R21) Writing zero to go bit does nothing
package dvs_pkg;
  localparam int RAIL_COUNT = 4;
  // Register sub-addresses
  localparam logic [7:0] FAULT_EVENT_STATUS_ADDR = 8'h02;
  localparam logic [7:0] RAIL_GOOD_STATUS_ADDR = 8'h13;
  localparam logic [7:0] VOLTAGE_CHANGE_CONTROL_ADDR = 8'h20;
  localparam logic [7:0] ALERT_CLEAR_ADDR = 8'h21;
  localparam logic [7:0] BUCK1_TARGET_FIRST_ADDR = 8'h23;
  localparam logic [7:0] BUCK1_TARGET_SECOND_ADDR = 8'h24;
  localparam logic [7:0] RAMP_RATE_CONTROL_ADDR = 8'h25;
  localparam logic [7:0] BUCK2_TARGET_FIRST_ADDR = 8'h26;
  localparam logic [7:0] BUCK2_TARGET_SECOND_ADDR = 8'h27;
  localparam logic [7:0] BUCK3_TARGET_FIRST_ADDR = 8'h29;
  localparam logic [7:0] BUCK3_TARGET_SECOND_ADDR = 8'h2a;
  localparam logic [7:0] LINEAR2_TARGET_FIRST_ADDR = 8'h32;
  localparam logic [7:0] LINEAR2_TARGET_SECOND_ADDR = 8'h33;
  // Reset values
  localparam logic [7:0] TARGET_RESET = 8'h19;
  localparam logic [7:0] RAMP_RATE_RESET = 8'hff;
  localparam logic [3:0] CHANGE_CTRL_RESET = 4'h0;
  // Field positions
  localparam int CODE_MSB = 4;
  localparam int GOOD_MASK_BIT = 5;
  localparam int EDGE_RATE_LSB = 6;
  localparam int FREQ_BIT = 5;
  localparam int PHASE_BIT = 6;
  localparam int KEEP_ALIVE_BIT = 7;
  localparam int AUX_MODE_BIT = 7;
  localparam int AUX_VOLT_LSB = 5;
  // Writable bits per register kind, unused bits read zero
  localparam logic [7:0] BUCK1_FIRST_MASK = 8'hff;
  localparam logic [7:0] BUCK_FIRST_MASK = 8'h3f;
  localparam logic [7:0] BUCK_SECOND_MASK = 8'hff;
  localparam logic [7:0] LINEAR2_FIRST_MASK = 8'hbf;
  localparam logic [7:0] LINEAR2_SECOND_BASE_MASK = 8'hff;
  localparam logic [7:0] LINEAR2_SECOND_ALT_MASK = 8'h7f;
  // DAC scale and ramp timing
  localparam int REF_BASE_UV = 362500;
  localparam int DAC_STEP_UV = 12500;
  localparam int SYS_CLK_MHZ = 20;
  localparam int RATE_UV_PER_US [4] = '{880, 1750, 3500, 7000};
  localparam logic [8:0] STEP_CYCLES [4] = '{
    9'(DAC_STEP_UV * SYS_CLK_MHZ / RATE_UV_PER_US[0]),
    9'(DAC_STEP_UV * SYS_CLK_MHZ / RATE_UV_PER_US[1]),
    9'(DAC_STEP_UV * SYS_CLK_MHZ / RATE_UV_PER_US[2]),
    9'(DAC_STEP_UV * SYS_CLK_MHZ / RATE_UV_PER_US[3])};

  typedef enum logic [3:0] {
    LINK_IDLE, LINK_DEV, LINK_ACK_DEV, LINK_SUB, LINK_ACK_SUB,
    LINK_WR, LINK_ACK_WR, LINK_RD, LINK_RD_ACK
  } link_phase_type;

  typedef struct packed {
    logic hit;
    logic second;
    logic [1:0] rail;
  } target_slot_type;

  typedef struct packed {
    logic [1:0] edge_rate;
    logic [2:0] buck_freq_sel;
    logic [2:0] buck_phase_sel;
    logic [3:0] keep_alive;
    logic aux_enable_by_reg;
    logic [1:0] aux_voltage_sel;
  } regulator_config_type;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [2:0] rd_sync;
    link_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] rd_hold;
    logic [7:0] sub_addr;
    logic [7:0] wr_data;
    logic is_read;
    logic nack;
    logic addr_tgl;
    logic wr_tgl;
    logic sda_oe;
  } link_state_type;

  typedef struct packed {
    logic [3:0][7:0] tgt_first;
    logic [3:0][7:0] tgt_second;
    logic [3:0] sel;
    logic [3:0] go;
    logic [7:0] ramp_rate;
    logic [3:0][4:0] cur_code;
    logic [3:0][8:0] step_cnt;
    logic [2:0] addr_sync;
    logic [2:0] wr_sync;
    logic [2:0] stby_sync;
    logic [7:0] good_s1;
    logic [7:0] good_s2;
    logic [3:0] fault_s1;
    logic [3:0] fault_s2;
    logic [3:0] fault_prev;
    logic [7:0] rd_data;
    logic rd_tgl;
    logic alert;
    logic power_good;
  } sys_state_type;
endpackage

// *** rtl/dynamic_voltage_target_regs.sv ***
`timescale 1ns/1ps
module dynamic_voltage_target_regs
  import dvs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h34,
  parameter bit ALT_VARIANT = 1'b0
) (
  input wire logic sys_clk, // Internal clock
  input wire logic reset_n, // Async reset, active low
  input wire logic link_clk, // Serial interface sampling clock
  input wire logic scl_in, // Serial clock pin level
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value
  output logic sda_oe, // Serial data drive enable
  input wire logic standby_target_select_pin, // Standby target select
  input wire logic aux_linear_enable_pin, // Aux regulator enable pin
  input wire logic output_enable_reg_bit6, // Aux enable bit of output enable reg
  input wire logic [7:0] rail_good_in, // Per-rail output good flags
  input wire logic [3:0] fault_in, // Thermal, undervoltage, near-uv, timeout
  output logic alert_n, // Alert output, active low
  output logic power_good_output, // Combined power good
  output logic [3:0][4:0] ref_code, // DAC codes per rail
  output regulator_config_type reg_config, // Regulator configuration
  output logic aux_enable // Resolved aux regulator enable
);

  // Parameter sanity
  if (DEVICE_ADDRESS[6:3] == 4'h0 || DEVICE_ADDRESS[6:3] == 4'hf) begin : g_bad_addr
    $error("Device address lies in a reserved range");
  end

  if (STEP_CYCLES[3] == 9'h000) begin : g_bad_step
    $error("Ramp step shorter than one clock");
  end

  link_state_type l, next_l;
  sys_state_type s, next_s;

  // Synced pins, bus conditions
  logic scl, scl_prev, sda, sda_prev;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // Core events and helpers
  logic addr_evt, wr_evt, stby, stby_edge, force_low, fault_rise;
  logic [4:0] tgt [RAIL_COUNT];
  logic [3:0] go_set;
  logic [7:0] rd_byte;
  logic [7:0] wmask;
  target_slot_type slot_rd, slot_wr;

  // Map a sub-address to a target register slot
  function automatic target_slot_type target_slot(input logic [7:0] a);
    target_slot_type t;
    t = '0;
    t.hit = 1'b1;
    case (a)
      BUCK1_TARGET_FIRST_ADDR: t.rail = 2'd0;
      BUCK1_TARGET_SECOND_ADDR: begin
        t.rail = 2'd0;
        t.second = 1'b1;
      end
      BUCK2_TARGET_FIRST_ADDR: t.rail = 2'd1;
      BUCK2_TARGET_SECOND_ADDR: begin
        t.rail = 2'd1;
        t.second = 1'b1;
      end
      BUCK3_TARGET_FIRST_ADDR: t.rail = 2'd2;
      BUCK3_TARGET_SECOND_ADDR: begin
        t.rail = 2'd2;
        t.second = 1'b1;
      end
      LINEAR2_TARGET_FIRST_ADDR: t.rail = 2'd3;
      LINEAR2_TARGET_SECOND_ADDR: begin
        t.rail = 2'd3;
        t.second = 1'b1;
      end
      default: t.hit = 1'b0;
    endcase
    return t;
  endfunction

  // Serial engine edge and condition detection
  assign scl = l.scl_sync[1];
  assign scl_prev = l.scl_sync[2];
  assign sda = l.sda_sync[1];
  assign sda_prev = l.sda_sync[2];
  assign scl_rise = scl & ~scl_prev;
  assign scl_fall = ~scl & scl_prev;
  assign bus_start = scl & scl_prev & sda_prev & ~sda;
  assign bus_stop = scl & scl_prev & ~sda_prev & sda;

  // Serial slave on the link clock
  always_comb begin
    next_l = l;
    // Pin synchronisers
    next_l.scl_sync = {l.scl_sync[1:0], scl_in};
    next_l.sda_sync = {l.sda_sync[1:0], sda_in};
    next_l.rd_sync = {l.rd_sync[1:0], s.rd_tgl};
    // Fresh read snapshot from core
    if (l.rd_sync[2] != l.rd_sync[1]) begin
      next_l.rd_hold = s.rd_data;
    end

    // Start and stop win
    if (bus_start) begin
      next_l.phase = LINK_DEV;
      next_l.bit_cnt = 4'h0;
      next_l.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_l.phase = LINK_IDLE;
      next_l.sda_oe = 1'b0;
    end else begin
      case (l.phase)
        // Wait for a start
        LINK_IDLE: begin
          next_l.sda_oe = 1'b0;
        end
        // Eight bits in, then ack
        LINK_DEV, LINK_SUB, LINK_WR: begin
          if (scl_rise) begin
            next_l.shift = {l.shift[6:0], sda};
            next_l.bit_cnt = l.bit_cnt + 4'h1;
          end else if (scl_fall && l.bit_cnt == 4'h8) begin
            next_l.bit_cnt = 4'h0;
            if (l.phase == LINK_DEV) begin
              if (l.shift[7:1] == DEVICE_ADDRESS) begin
                next_l.phase = LINK_ACK_DEV;
                next_l.is_read = l.shift[0];
                next_l.sda_oe = 1'b1;
              end else begin
                next_l.phase = LINK_IDLE;
              end
            end else if (l.phase == LINK_SUB) begin
              // Sub-address acknowledged here; event carries it to the core
              next_l.phase = LINK_ACK_SUB;
              next_l.sub_addr = l.shift;
              next_l.addr_tgl = ~l.addr_tgl; // R03
              next_l.sda_oe = 1'b1;
            end else begin
              next_l.phase = LINK_ACK_WR;
              next_l.wr_data = l.shift;
              next_l.wr_tgl = ~l.wr_tgl;
              next_l.sda_oe = 1'b1;
            end
          end
        end
        // Read data or sub-address next
        LINK_ACK_DEV: begin
          if (scl_fall) begin
            if (l.is_read) begin
              next_l.phase = LINK_RD;
              next_l.sda_oe = ~l.rd_hold[7];
              next_l.tx = {l.rd_hold[6:0], 1'b0};
              next_l.bit_cnt = 4'h1;
            end else begin
              next_l.phase = LINK_SUB;
              next_l.sda_oe = 1'b0;
            end
          end
        end
        // Release after our ack
        LINK_ACK_SUB, LINK_ACK_WR: begin
          if (scl_fall) begin
            next_l.phase = LINK_WR;
            next_l.sda_oe = 1'b0;
          end
        end
        // One read bit per clock fall
        LINK_RD: begin
          if (scl_fall) begin
            if (l.bit_cnt == 4'h8) begin
              next_l.phase = LINK_RD_ACK;
              next_l.sda_oe = 1'b0;
            end else begin
              next_l.sda_oe = ~l.tx[7];
              next_l.tx = {l.tx[6:0], 1'b0};
              next_l.bit_cnt = l.bit_cnt + 4'h1;
            end
          end
        end
        // Host ack repeats, nack ends
        LINK_RD_ACK: begin
          if (scl_rise) begin
            next_l.nack = sda;
          end else if (scl_fall) begin
            if (l.nack) begin
              next_l.phase = LINK_IDLE;
            end else begin
              next_l.phase = LINK_RD;
              next_l.sda_oe = ~l.rd_hold[7];
              next_l.tx = {l.rd_hold[6:0], 1'b0};
              next_l.bit_cnt = 4'h1;
            end
          end
        end
        // Stray phase back to idle
        default: begin
          next_l.phase = LINK_IDLE;
          next_l.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Link state register
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      l <= '0;
      // Idle-high pins, no false edge
      l.scl_sync <= 3'h7;
      l.sda_sync <= 3'h7;
      l.phase <= LINK_IDLE;
    end else begin
      l <= next_l;
    end
  end

  // Core-side events and pin levels
  assign addr_evt = s.addr_sync[2] ^ s.addr_sync[1];
  assign wr_evt = s.wr_sync[2] ^ s.wr_sync[1];
  assign stby = s.stby_sync[1];
  assign stby_edge = s.stby_sync[2] ^ s.stby_sync[1];

  // Target slot of sub-address
  assign slot_rd = target_slot(l.sub_addr);
  assign slot_wr = target_slot(l.sub_addr);

  // Unmasked ramp drops power good
  assign force_low = |(s.go & ~{s.tgt_first[3][GOOD_MASK_BIT], s.tgt_first[2][GOOD_MASK_BIT],
                                s.tgt_first[1][GOOD_MASK_BIT], s.tgt_first[0][GOOD_MASK_BIT]}); // R08
  assign fault_rise = |(s.fault_s2 & ~s.fault_prev);

  // Selected target per rail
  always_comb begin
    for (int i = 0; i < RAIL_COUNT; i++) begin
      tgt[i] = (s.sel[i] | stby) ? s.tgt_second[i][CODE_MSB:0] : s.tgt_first[i][CODE_MSB:0]; // R01 R05 R06
    end
  end

  // Read data for the addressed register
  always_comb begin
    rd_byte = 8'h00;
    if (slot_rd.hit) begin
      rd_byte = slot_rd.second ? s.tgt_second[slot_rd.rail] : s.tgt_first[slot_rd.rail];
    end else begin
      // Status and control registers
      case (l.sub_addr)
        FAULT_EVENT_STATUS_ADDR: rd_byte = {s.fault_s2[3], 1'b0, s.fault_s2[2:0], 3'h0}; // R20
        RAIL_GOOD_STATUS_ADDR: rd_byte = s.good_s2; // R19
        VOLTAGE_CHANGE_CONTROL_ADDR: rd_byte = {s.sel[3], s.go[3], s.sel[2], s.go[2],
                                                s.sel[1], s.go[1], s.sel[0], s.go[0]};
        RAMP_RATE_CONTROL_ADDR: rd_byte = s.ramp_rate;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Writable bit mask of the addressed target register
  always_comb begin
    case (l.sub_addr)
      BUCK1_TARGET_FIRST_ADDR: wmask = BUCK1_FIRST_MASK;
      BUCK2_TARGET_FIRST_ADDR, BUCK3_TARGET_FIRST_ADDR: wmask = BUCK_FIRST_MASK;
      LINEAR2_TARGET_FIRST_ADDR: wmask = LINEAR2_FIRST_MASK;
      // Aux mode bit in base variant only
      LINEAR2_TARGET_SECOND_ADDR: wmask = ALT_VARIANT ? LINEAR2_SECOND_ALT_MASK : LINEAR2_SECOND_BASE_MASK; // R18
      default: wmask = BUCK_SECOND_MASK;
    endcase
  end

  // Core logic: registers, ramps, alert, power good
  always_comb begin
    next_s = s;
    go_set = 4'h0;
    // Event toggles from link side, standby pin sync
    next_s.addr_sync = {s.addr_sync[1:0], l.addr_tgl};
    next_s.wr_sync = {s.wr_sync[1:0], l.wr_tgl};
    next_s.stby_sync = {s.stby_sync[1:0], standby_target_select_pin};
    // Status inputs through two flops
    next_s.good_s1 = rail_good_in;
    next_s.good_s2 = s.good_s1;
    next_s.fault_s1 = fault_in;
    next_s.fault_s2 = s.fault_s1;
    next_s.fault_prev = s.fault_s2;

    // Ramp one code per step toward the selected target
    for (int i = 0; i < RAIL_COUNT; i++) begin
      if (s.go[i]) begin
        // Target reached: go drops
        if (s.cur_code[i] == tgt[i]) begin
          next_s.go[i] = 1'b0; // R02
          next_s.step_cnt[i] = 9'h000;
        end else if (s.step_cnt[i] == 9'h000) begin
          next_s.cur_code[i] = (s.cur_code[i] < tgt[i]) ? s.cur_code[i] + 5'h01 : s.cur_code[i] - 5'h01;
          next_s.step_cnt[i] = STEP_CYCLES[s.ramp_rate[2*i +: 2]] - 9'h001; // R14 R15
        end else begin
          next_s.step_cnt[i] = s.step_cnt[i] - 9'h001;
        end
      end
    end

    // Standby change relaunches all ramps
    if (stby_edge) begin
      go_set = 4'hf; // R06
    end

    // Sub-address event: latch read data; alert clears only at the alert clear address
    if (addr_evt) begin
      next_s.rd_data = rd_byte;
      next_s.rd_tgl = ~s.rd_tgl;
    end

    // Register write; alert clear data falls through unused
    if (wr_evt) begin
      // Undefined target bits dropped
      if (slot_wr.hit) begin
        if (slot_wr.second) begin
          next_s.tgt_second[slot_wr.rail] = l.wr_data & wmask;
        end else begin
          next_s.tgt_first[slot_wr.rail] = l.wr_data & wmask;
        end
      end else begin
        case (l.sub_addr)
          VOLTAGE_CHANGE_CONTROL_ADDR: begin
            next_s.sel = {l.wr_data[7], l.wr_data[5], l.wr_data[3], l.wr_data[1]};
            go_set = go_set | {l.wr_data[6], l.wr_data[4], l.wr_data[2], l.wr_data[0]}; // R07 R21
          end
          RAMP_RATE_CONTROL_ADDR: next_s.ramp_rate = l.wr_data; // R14
          default: next_s.ramp_rate = s.ramp_rate; // R04
        endcase
      end
    end

    // A new go request wins over completion
    next_s.go = next_s.go | go_set; // R02
    next_s.alert = fault_rise | (s.alert & ~(addr_evt && l.sub_addr == ALERT_CLEAR_ADDR)); // R03
    next_s.power_good = (&s.good_s2) & ~force_low; // R08
  end

  // Core state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      // Register defaults
      s.tgt_first <= {RAIL_COUNT{TARGET_RESET}}; // R13
      s.tgt_second <= {RAIL_COUNT{TARGET_RESET}}; // R13
      s.cur_code <= {RAIL_COUNT{TARGET_RESET[CODE_MSB:0]}};
      s.sel <= CHANGE_CTRL_RESET;
      s.go <= CHANGE_CTRL_RESET;
      s.ramp_rate <= RAMP_RATE_RESET; // R15
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe = l.sda_oe;
  assign alert_n = ~s.alert;
  assign power_good_output = s.power_good;
  assign ref_code = s.cur_code; // R01

  // Regulator configuration fields
  assign reg_config.edge_rate = s.tgt_first[0][EDGE_RATE_LSB +: 2]; // R09
  assign reg_config.buck_freq_sel = {s.tgt_second[2][FREQ_BIT], s.tgt_second[1][FREQ_BIT],
                                     s.tgt_second[0][FREQ_BIT]}; // R10
  assign reg_config.buck_phase_sel = {s.tgt_second[2][PHASE_BIT], s.tgt_second[1][PHASE_BIT],
                                      s.tgt_second[0][PHASE_BIT]}; // R12
  assign reg_config.keep_alive = {s.tgt_first[3][KEEP_ALIVE_BIT], s.tgt_second[2][KEEP_ALIVE_BIT],
                                  s.tgt_second[1][KEEP_ALIVE_BIT], s.tgt_second[0][KEEP_ALIVE_BIT]}; // R11
  assign reg_config.aux_enable_by_reg = s.tgt_second[3][AUX_MODE_BIT]; // R16
  assign reg_config.aux_voltage_sel = s.tgt_second[3][AUX_VOLT_LSB +: 2]; // R17 R18

  // Aux enable from pin or register
  assign aux_enable = s.tgt_second[3][AUX_MODE_BIT] ? output_enable_reg_bit6 : aux_linear_enable_pin; // R16

endmodule

// *** bench/dvs_props.sv ***
`timescale 1ns/1ps
module dvs_props
  import dvs_pkg::*;
(
  input wire logic sys_clk, // Core clock
  input wire logic reset_n, // Async reset
  input wire logic link_clk, // Link clock
  input wire logic scl_in, // Serial clock level
  input wire logic sda_oe, // Data pull enable
  input wire logic aux_linear_enable_pin, // Aux pin
  input wire logic output_enable_reg_bit6, // Aux register bit
  input wire logic [7:0] rail_good_in, // Rail flags
  input wire logic [3:0] fault_in, // Fault flags
  input wire logic alert_n, // Alert output
  input wire logic power_good_output, // Power good
  input wire logic [3:0][4:0] ref_code, // DAC codes
  input wire regulator_config_type reg_config, // Config
  input wire logic aux_enable // Aux enable
);
  logic scl_q;
  logic [4:0] code_q;
  logic [7:0] idle;
  logic [7:0] gap;
  // Cycles since serial clock moved and since rail 0 stepped
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      code_q <= 5'h19;
      idle <= 8'h00;
      gap <= 8'h00;
    end else begin
      scl_q <= scl_in;
      code_q <= ref_code[0];
      idle <= (scl_in != scl_q) ? 8'h00 : idle + {7'h00, idle != 8'hff};
      gap <= (ref_code[0] != code_q) ? 8'h00 : gap + {7'h00, gap != 8'hff};
    end
  end

  alert_rise_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    |(fault_in & ~$past(fault_in)) |-> ##[1:5] !alert_n) else $error("alert missed a fault");
  alert_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(alert_n) |-> idle < 8'h28) else $error("alert released without bus access");
  pg_rails_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_good_output |-> &$past(rail_good_in, 3)) else $error("power good with a rail low");
  step_rail1_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ref_code[1] != $past(ref_code[1]) |-> ref_code[1] == $past(ref_code[1]) + 5'h1
      || ref_code[1] == $past(ref_code[1]) - 5'h1) else $error("code jumped");
  step_gap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ref_code[0] != code_q |-> gap >= 8'h1e) else $error("steps too close");
  aux_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    aux_enable == (reg_config.aux_enable_by_reg ? output_enable_reg_bit6 : aux_linear_enable_pin))
    else $error("aux enable source wrong");
  cfg_stable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    idle > 8'h28 |-> $stable(reg_config)) else $error("config moved without access");
  ack_low_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(sda_oe) |-> !scl_in) else $error("data drive moved with clock high");
endmodule
bind dynamic_voltage_target_regs dvs_props u_dvs_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .link_clk(link_clk), .scl_in(scl_in), .sda_oe(sda_oe), .aux_linear_enable_pin(aux_linear_enable_pin),
  .output_enable_reg_bit6(output_enable_reg_bit6), .rail_good_in(rail_good_in), .fault_in(fault_in),
  .alert_n(alert_n), .power_good_output(power_good_output), .ref_code(ref_code),
  .reg_config(reg_config), .aux_enable(aux_enable));

// *** bench/i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic sys_clk, // Pacing clock
  input wire logic sda_line, // Resolved data wire
  output logic scl, // Serial clock drive
  output logic sda_low // Pulls data wire low
);
  // Bus starts released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit time, moves just after a core edge
  task automatic q();
    repeat (5) @(posedge sys_clk);
    #2;
  endtask
  // One bit slot, wire sampled late in the high phase
  task automatic slot(input logic b, output logic r);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda_line;
    scl = 1'b0;
    q();
  endtask
  // Start and stop conditions
  task automatic start();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // Byte out and in, ninth slot released for ack or nack
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) slot(d[i], r[i]);
    slot(1'b1, a);
    ack = !a;
  endtask
  // Register write, or sub-address only
  task automatic wr(input logic [7:0] sub, input logic [7:0] d, input logic with_data);
    logic [7:0] r;
    logic a;
    start();
    xfer(8'h68, r, a);
    xfer(sub, r, a);
    if (with_data) xfer(d, r, a);
    stop();
  endtask
  // Register read of one byte
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    wr(sub, 8'h00, 1'b0);
    start();
    xfer(8'h69, d, a);
    xfer(8'hff, d, a);
    stop();
  endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import dvs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda_line;
  logic standby_target_select_pin = 1'b0;
  logic aux_pin = 1'b0;
  logic oe_bit6 = 1'b0;
  logic [7:0] rail_good_in = 8'hff;
  logic [3:0] fault_in = 4'h0;
  logic alert_n;
  logic power_good_output;
  logic aux_enable;
  logic [3:0][4:0] ref_code;
  regulator_config_type reg_config;
  int bad_count = 0;
  int n_compared = 0;
  // Open-drain data wire with pull-up
  assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_low;
  dynamic_voltage_target_regs u_dynamic_voltage_target_regs (.sys_clk(sys_clk), .reset_n(reset_n),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .standby_target_select_pin(standby_target_select_pin), .aux_linear_enable_pin(aux_pin),
    .output_enable_reg_bit6(oe_bit6), .rail_good_in(rail_good_in), .fault_in(fault_in),
    .alert_n(alert_n), .power_good_output(power_good_output), .ref_code(ref_code),
    .reg_config(reg_config), .aux_enable(aux_enable));
  i2c_host_model u_i2c_host_model (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // Core and link clocks, unrelated phase
  initial begin
    forever #25 sys_clk = !sys_clk;
  end
  initial begin
    #7;
    forever #16 link_clk = !link_clk;
  end
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_i2c_host_model.wr(a, d, 1'b1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_i2c_host_model.rd(a, d);
    cmp({8'h00, d}, {8'h00, e});
  endtask
  task automatic wait_code(input int r, input logic [4:0] c);
    int n;
    n = 0;
    while (ref_code[r] !== c && n < 3000) begin
      cyc(1);
      n++;
    end
    cmp(16'(ref_code[r]), 16'(c));
  endtask
  // Reset contents of targets, ramp rates and control
  task automatic t_reset();
    logic [7:0] tg [8] = '{BUCK1_TARGET_FIRST_ADDR, BUCK1_TARGET_SECOND_ADDR, BUCK2_TARGET_FIRST_ADDR,
      BUCK2_TARGET_SECOND_ADDR, BUCK3_TARGET_FIRST_ADDR, BUCK3_TARGET_SECOND_ADDR,
      LINEAR2_TARGET_FIRST_ADDR, LINEAR2_TARGET_SECOND_ADDR};
    for (int i = 0; i < 4; i++) cmp(16'(ref_code[i]), 16'h0019);
    foreach (tg[i]) rdchk(tg[i], 8'h19);
    rdchk(RAMP_RATE_CONTROL_ADDR, 8'hff);
    rdchk(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h00);
  endtask
  // Field masks, config bits, unmapped place, aux enable source
  task automatic t_config();
    logic [7:0] ad [8] = '{BUCK1_TARGET_FIRST_ADDR, BUCK2_TARGET_FIRST_ADDR, BUCK1_TARGET_SECOND_ADDR,
      BUCK2_TARGET_SECOND_ADDR, BUCK3_TARGET_SECOND_ADDR, LINEAR2_TARGET_FIRST_ADDR,
      LINEAR2_TARGET_SECOND_ADDR, 8'h28};
    logic [7:0] wd [8] = '{8'hd9, 8'hd9, 8'hb9, 8'h59, 8'hf9, 8'hd9, 8'hd9, 8'h55};
    logic [7:0] ex [8] = '{8'hd9, 8'h19, 8'hb9, 8'h59, 8'hf9, 8'h99, 8'hd9, 8'h00};
    oe_bit6 = 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(ad[i], wd[i]);
      rdchk(ad[i], ex[i]);
    end
    cmp(16'(reg_config), 16'h776e);
    cmp(16'(aux_enable), 16'h0001);
    wr(LINEAR2_TARGET_SECOND_ADDR, 8'h19);
    cmp(16'(aux_enable), 16'h0000);
  endtask
  // Slow ramp, zero go write mid-ramp, self clear, power good mask
  task automatic t_ramp();
    wr(RAMP_RATE_CONTROL_ADDR, 8'hf3);
    wr(BUCK2_TARGET_SECOND_ADDR, 8'h1f);
    wr(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h0c);
    cmp(16'(ref_code[1]), 16'h001a);
    cmp(16'(power_good_output), 16'h0000);
    wr(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h08);
    rdchk(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h0c);
    wait_code(1, 5'h1f);
    cyc(5);
    rdchk(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h08);
    cmp(16'(power_good_output), 16'h0001);
    wr(BUCK2_TARGET_FIRST_ADDR, 8'h39);
    wr(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h04);
    cmp(16'(power_good_output), 16'h0001);
    wait_code(1, 5'h19);
  endtask
  // Standby pin selects second targets and back
  task automatic t_standby();
    wr(BUCK1_TARGET_SECOND_ADDR, 8'h10);
    standby_target_select_pin = 1'b1;
    wait_code(0, 5'h10);
    wait_code(1, 5'h1f);
    standby_target_select_pin = 1'b0;
    wait_code(0, 5'h19);
    wait_code(1, 5'h19);
  endtask
  // Alert raise and clear by write and by read, status registers
  task automatic t_alert();
    logic [7:0] d;
    fault_in = 4'hf;
    cyc(8);
    cmp(16'(alert_n), 16'h0000);
    rdchk(FAULT_EVENT_STATUS_ADDR, 8'hb8);
    wr(ALERT_CLEAR_ADDR, 8'hff);
    cmp(16'(alert_n), 16'h0001);
    rdchk(VOLTAGE_CHANGE_CONTROL_ADDR, 8'h00);
    fault_in = 4'h0;
    cyc(8);
    fault_in = 4'h1;
    cyc(8);
    cmp(16'(alert_n), 16'h0000);
    u_i2c_host_model.rd(ALERT_CLEAR_ADDR, d);
    cmp(16'(alert_n), 16'h0001);
    rail_good_in = 8'ha5;
    rdchk(RAIL_GOOD_STATUS_ADDR, 8'ha5);
    cmp(16'(power_good_output), 16'h0000);
  endtask
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    cyc(10);
    t_reset();
    t_config();
    t_ramp();
    t_standby();
    t_alert();
    summarize();
  end
  // Watchdog
  initial begin
    #4000000;
    bad_count++;
    summarize();
  end
endmodule
